// >>> common/pio_map.svh
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH
// byte addresses on the register bus
`define PIO_ADDR_P0_LATCH 12'h000
`define PIO_ADDR_P1_LATCH 12'h004
`define PIO_ADDR_P2_LATCH 12'h008
`define PIO_ADDR_P3_LATCH 12'h00c
`define PIO_ADDR_P4_LATCH 12'h010
`define PIO_ADDR_P1_DIR 12'h014
`define PIO_ADDR_P3_DIR 12'h018
`define PIO_ADDR_P4_DIR 12'h01c
`define PIO_ADDR_P0_PIN 12'h020
`define PIO_ADDR_P2_PIN 12'h024
`define PIO_ADDR_CONV 12'h028
`define PIO_ADDR_EXT_IRQ 12'h02c
`define PIO_ADDR_MODE 12'h030
// field positions
`define PIO_CONV_AIN_DIS_BIT 3
`define PIO_CONV_SEL_LSB 0
`define PIO_CONV_SEL_W 3
`define PIO_EXT_IRQ_ZERO_EN_BIT 0
`define PIO_EXT_IRQ_ZERO_FLAG_BIT 1
`define PIO_MODE_DUAL_CLK_BIT 0
// reset values
`define PIO_RST_P0_LATCH 8'hff
`define PIO_RST_P1_LATCH 6'h00
`define PIO_RST_P2_LATCH 3'h7
`define PIO_RST_P3_LATCH 8'h00
`define PIO_RST_P4_LATCH 8'h00
`define PIO_RST_DIR 8'h00
`define PIO_RST_AIN_DIS 1'b1
// filler for bits that do not exist
`define PIO_UNDEF_FILL 8'h00
`endif

// >>> common/pio_pkg.sv
package pio_pkg;
    typedef struct packed {
        logic [7:0] p0;
        logic [5:0] p1;
        logic [2:0] p2;
        logic [7:0] p3;
        logic [7:0] p4;
    } pio_pins_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pio_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pio_apb_rsp_t;

    typedef enum logic [2:0] {
        PIO_ST_IDLE = 3'b001,
        PIO_ST_SETUP = 3'b010,
        PIO_ST_ACCESS = 3'b100
    } pio_bus_state_t;
endpackage : pio_pkg

// >>> dv/parallel_io_ports_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pio_map.svh"
module parallel_io_ports_test import pio_pkg::*;;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    pio_apb_req_t apb = '0;
    pio_apb_rsp_t rsp;
    pio_pins_t pin, pout, poe, board;
    pio_pins_t alt = '1;
    logic irq0_n, irq20_n, osc;
    logic [31:0] seed = 32'h000132ef;
    logic [32:0] exp_q[$];
    logic [7:0] l, d, m;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [11:0] ra[9] = '{`PIO_ADDR_P0_LATCH, `PIO_ADDR_P1_LATCH, `PIO_ADDR_P2_LATCH, `PIO_ADDR_P1_DIR,
        `PIO_ADDR_P3_DIR, `PIO_ADDR_P4_DIR, `PIO_ADDR_CONV, `PIO_ADDR_EXT_IRQ, `PIO_ADDR_MODE};
    logic [7:0] re[9] = '{8'hff, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
    logic [11:0] la[3] = '{`PIO_ADDR_P1_LATCH, `PIO_ADDR_P3_LATCH, `PIO_ADDR_P4_LATCH};
    logic [11:0] da[3] = '{`PIO_ADDR_P1_DIR, `PIO_ADDR_P3_DIR, `PIO_ADDR_P4_DIR};

    // secondary outputs idle high so the latch alone decides the pins until port 0 is tried
    pio_ports DUT (.i_clk(i_clk), .i_rst(i_rst), .i_apb(apb), .o_apb(rsp), .i_pin(pin), .i_alt_out(alt),
        .o_pin(pout), .o_pin_oe(poe), .o_ext_irq_zero_n(irq0_n), .o_ext_irq_p20_n(irq20_n),
        .o_sub_osc_sel(osc));
    pio_pads u_pads (.i_drv(pout), .i_oe(poe), .i_board(board), .o_pad(pin));

    initial forever #5 i_clk = ~i_clk;

    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd

    function automatic logic [7:0] pick(input pio_pins_t s, input int k);
        return (k == 0) ? {2'b00, s.p1} : (k == 1) ? s.p3 : s.p4;
    endfunction : pick

    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic complete_run();
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [7:0] e);
        @(posedge i_clk);
        if (!w)
            exp_q.push_back({(a > `PIO_ADDR_MODE) || (a[1:0] != 2'b00), 24'h0, e});
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge i_clk);
        apb.penable <= 1'b1;
        @(posedge i_clk);
        while (!rsp.pready)
            @(posedge i_clk);
        apb <= '0;
    endtask : xfer

    // read data and error are taken at the edge where ready is sampled high
    always @(posedge i_clk) begin
        if (apb.psel && apb.penable && rsp.pready && !apb.pwrite)
            chk({rsp.pslverr, rsp.prdata}, exp_q.pop_front());
    end

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        board.p0 = rnd();
        board.p1 = 6'(rnd());
        board.p2 = 3'h7;
        board.p3 = rnd();
        board.p4 = rnd();
        re[1] = {2'b00, board.p1};
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 9; i++)
            xfer(1'b0, ra[i], 32'h0, re[i]);
        @(negedge i_clk);
        chk(poe, 40'h0);
        chk(irq0_n, 1'b1);
        xfer(1'b1, `PIO_ADDR_EXT_IRQ, 32'h1, 8'h0);
        xfer(1'b0, `PIO_ADDR_EXT_IRQ, 32'h0, 8'h01);
        @(negedge i_clk);
        chk(irq0_n, board.p0[0]);
        xfer(1'b1, `PIO_ADDR_P2_LATCH, 32'h6, 8'h0);
        xfer(1'b0, `PIO_ADDR_P2_PIN, 32'h0, 8'h06);
        @(negedge i_clk);
        chk(irq20_n, 1'b0);
        xfer(1'b1, `PIO_ADDR_MODE, 32'h1, 8'h0);
        xfer(1'b0, `PIO_ADDR_MODE, 32'h0, 8'h01);
        @(negedge i_clk);
        chk(osc, 1'b1);
        l = rnd();
        xfer(1'b1, `PIO_ADDR_P0_LATCH, {24'h0, l}, 8'h0);
        xfer(1'b0, `PIO_ADDR_P0_LATCH, 32'h0, l);
        xfer(1'b0, `PIO_ADDR_P0_PIN, 32'h0, (l | 8'h01) & board.p0);
        @(posedge i_clk);
        alt.p0 <= rnd();
        repeat (2) @(negedge i_clk);
        chk(pout.p0, (l & alt.p0) | 8'h01);
        for (int k = 0; k < 3; k++) begin
            m = (k == 0) ? 8'h3f : 8'hff;
            l = rnd() & m;
            d = rnd() & m;
            xfer(1'b1, la[k], {24'h0, l}, 8'h0);
            xfer(1'b1, da[k], {24'h0, d}, 8'h0);
            xfer(1'b0, la[k], 32'h0, (l & d) | (pick(board, k) & ~d));
            xfer(1'b0, da[k], 32'h0, d);
            @(negedge i_clk);
            chk(pick(poe, k), d);
            chk(pick(pout, k) & d, l & d);
        end
        xfer(1'b1, `PIO_ADDR_P3_LATCH, 32'hff, 8'h0);
        xfer(1'b1, `PIO_ADDR_P3_DIR, 32'hff, 8'h0);
        for (int c = 0; c < 8; c++) begin
            m = ~(8'h01 << c);
            xfer(1'b1, `PIO_ADDR_CONV, 32'(c), 8'h0);
            xfer(1'b0, `PIO_ADDR_P3_LATCH, 32'h0, m);
            @(negedge i_clk);
            chk(poe.p3, m);
        end
        xfer(1'b1, 12'h040, 32'hff, 8'h0);
        xfer(1'b0, 12'h040, 32'h0, 8'h00);
        complete_run();
    end
endmodule : parallel_io_ports_test
`default_nettype wire

// >>> dv/pio_pads.sv
`timescale 1ns/1ps
`default_nettype none
module pio_pads import pio_pkg::*; (
    // design side
    input wire pio_pins_t i_drv,
    input wire pio_pins_t i_oe,
    // board side
    input wire pio_pins_t i_board,
    output var pio_pins_t o_pad
);
    // a pin left undriven by the port follows the board circuitry
    assign o_pad = (i_drv & i_oe) | (i_board & ~i_oe);
endmodule : pio_pads
`default_nettype wire

// >>> dv/pio_ports_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "pio_map.svh"
module pio_ports_chk import pio_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register bus
    input wire pio_apb_req_t i_apb,
    input wire pio_apb_rsp_t o_apb,
    // pins
    input wire pio_pins_t i_pin,
    input wire pio_pins_t i_alt_out,
    input wire pio_pins_t o_pin,
    input wire pio_pins_t o_pin_oe,
    // secondary signals
    input wire logic o_ext_irq_zero_n,
    input wire logic o_ext_irq_p20_n,
    input wire logic o_sub_osc_sel
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic acc = i_apb.psel && i_apb.penable && o_apb.pready;
    wire logic wr = acc && i_apb.pwrite;
    a_ready_after_setup: assert property (i_apb.psel && !i_apb.penable |=> o_apb.pready)
        else $error("no ready after setup");
    a_ready_in_access: assert property (o_apb.pready |-> i_apb.psel && i_apb.penable)
        else $error("ready outside access");
    a_ready_one_cycle: assert property (o_apb.pready |=> !o_apb.pready)
        else $error("ready held");
    a_unmapped_err: assert property (acc && i_apb.paddr > 12'h030 |-> o_apb.pslverr)
        else $error("unmapped not refused");
    a_upper_zero: assert property (acc && !i_apb.pwrite |-> o_apb.prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_p0_open_drain: assert property (1'b1 |=> o_pin_oe.p0 == ~o_pin.p0)
        else $error("port0 drives high");
    a_p2_open_drain: assert property (1'b1 |=> o_pin_oe.p2 == ~o_pin.p2)
        else $error("port2 drives high");
    a_p4_write_pin: assert property (wr && i_apb.paddr == `PIO_ADDR_P4_LATCH |->
        ##2 (o_pin.p4 & o_pin_oe.p4) == ($past(i_apb.pwdata[7:0], 2) & o_pin_oe.p4))
        else $error("port4 pin missed write");
    a_p1_dir_oe: assert property (wr && i_apb.paddr == `PIO_ADDR_P1_DIR |->
        ##2 o_pin_oe.p1 == $past(i_apb.pwdata[5:0], 2))
        else $error("port1 enable differs");
endmodule : pio_ports_chk
bind pio_ports pio_ports_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_apb(i_apb), .o_apb(o_apb),
    .i_pin(i_pin), .i_alt_out(i_alt_out), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
    .o_ext_irq_zero_n(o_ext_irq_zero_n), .o_ext_irq_p20_n(o_ext_irq_p20_n), .o_sub_osc_sel(o_sub_osc_sel));
`default_nettype wire

// >>> hw/pio_ports.sv
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pio_map.svh"
module pio_ports import pio_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register bus
    input wire pio_apb_req_t i_apb,
    output var pio_apb_rsp_t o_apb,
    // pins
    input wire pio_pins_t i_pin,
    input wire pio_pins_t i_alt_out,
    output var pio_pins_t o_pin,
    output var pio_pins_t o_pin_oe,
    // secondary signals
    output logic o_ext_irq_zero_n,
    output logic o_ext_irq_p20_n,
    output logic o_sub_osc_sel
);
    pio_bus_state_t st_r;
    logic [7:0] p0_latch_r;
    logic [5:0] p1_latch_r;
    logic [2:0] p2_latch_r;
    logic [7:0] p3_latch_r;
    logic [7:0] p4_latch_r;
    logic [5:0] p1_dir_r;
    logic [7:0] p3_dir_r;
    logic [7:0] p4_dir_r;
    logic ain_dis_r;
    logic [`PIO_CONV_SEL_W-1:0] ain_sel_r;
    logic irq0_en_r;
    logic irq0_flag_r;
    logic dual_clk_r;
    logic p20_prev_r;
    logic [31:0] rdata;
    logic [12:0] sel;
    logic [12:0] we;
    logic [5:0] p1_rd;
    logic [7:0] p3_rd;
    logic [7:0] p4_rd;
    logic hit;
    logic wr_en;
    logic [7:0] p3_ana;
    logic [7:0] p3_dir_eff;
    pio_pins_t drv;

    // mixed read: pin for inputs, latch for outputs
    function automatic logic [7:0] mix_read(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] pin);
        mix_read = (dir & lat) | (~dir & pin);
    endfunction : mix_read

    // one-hot register select, used by the converter/mode and ext irq write strobes; the latch and direction block decodes paddr itself
    function automatic logic [12:0] reg_sel(input logic [11:0] a);
        reg_sel = 13'h0000;
        unique case (a)
            `PIO_ADDR_P0_LATCH: reg_sel[0] = 1'b1;
            `PIO_ADDR_P1_LATCH: reg_sel[1] = 1'b1;
            `PIO_ADDR_P2_LATCH: reg_sel[2] = 1'b1;
            `PIO_ADDR_P3_LATCH: reg_sel[3] = 1'b1;
            `PIO_ADDR_P4_LATCH: reg_sel[4] = 1'b1;
            `PIO_ADDR_P1_DIR: reg_sel[5] = 1'b1;
            `PIO_ADDR_P3_DIR: reg_sel[6] = 1'b1;
            `PIO_ADDR_P4_DIR: reg_sel[7] = 1'b1;
            `PIO_ADDR_P0_PIN: reg_sel[8] = 1'b1;
            `PIO_ADDR_P2_PIN: reg_sel[9] = 1'b1;
            `PIO_ADDR_CONV: reg_sel[10] = 1'b1;
            `PIO_ADDR_EXT_IRQ: reg_sel[11] = 1'b1;
            `PIO_ADDR_MODE: reg_sel[12] = 1'b1;
            default: begin
            end
        endcase
    endfunction : reg_sel

    always_comb begin
        p3_ana = 8'h00;
        if (!ain_dis_r) begin
            p3_ana[ain_sel_r] = 1'b1;
        end
    end

    assign p3_dir_eff = p3_dir_r & ~p3_ana;
    assign wr_en = (st_r == PIO_ST_ACCESS) && i_apb.psel && i_apb.penable && i_apb.pwrite;
    assign sel = reg_sel(i_apb.paddr);
    assign we = wr_en ? sel : 13'h0000;

    // mixed reads come straight off the pads; the read word register is the only sample
    assign p1_rd = 6'(mix_read({2'b00, p1_dir_r}, {2'b00, p1_latch_r}, {2'b00, i_pin.p1}));
    assign p3_rd = mix_read(p3_dir_eff, p3_latch_r, i_pin.p3) & ~p3_ana;
    assign p4_rd = mix_read(p4_dir_r, p4_latch_r, i_pin.p4);

    // bus phase tracking; the pin snapshot is taken in setup
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= PIO_ST_IDLE;
        end else begin
            unique case (st_r)
                PIO_ST_IDLE: begin
                    if (i_apb.psel) begin
                        st_r <= PIO_ST_ACCESS;
                    end
                end
                PIO_ST_SETUP: begin
                    st_r <= PIO_ST_ACCESS;
                end
                PIO_ST_ACCESS: begin
                    st_r <= (i_apb.psel && !i_apb.penable) ? PIO_ST_ACCESS : PIO_ST_IDLE;
                end
                default: begin
                    st_r <= PIO_ST_IDLE;
                end
            endcase
        end
    end

    // output latches and direction registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            p0_latch_r <= `PIO_RST_P0_LATCH;
            p1_latch_r <= `PIO_RST_P1_LATCH;
            p2_latch_r <= `PIO_RST_P2_LATCH;
            p3_latch_r <= `PIO_RST_P3_LATCH;
            p4_latch_r <= `PIO_RST_P4_LATCH;
            p1_dir_r <= 6'(`PIO_RST_DIR);
            p3_dir_r <= `PIO_RST_DIR;
            p4_dir_r <= `PIO_RST_DIR;
        end else if (wr_en) begin
            unique case (i_apb.paddr)
                `PIO_ADDR_P0_LATCH: p0_latch_r <= i_apb.pwdata[7:0];
                `PIO_ADDR_P1_LATCH: p1_latch_r <= i_apb.pwdata[5:0];
                `PIO_ADDR_P2_LATCH: p2_latch_r <= i_apb.pwdata[2:0];
                `PIO_ADDR_P3_LATCH: p3_latch_r <= i_apb.pwdata[7:0];
                `PIO_ADDR_P4_LATCH: p4_latch_r <= i_apb.pwdata[7:0];
                `PIO_ADDR_P1_DIR: p1_dir_r <= i_apb.pwdata[5:0];
                `PIO_ADDR_P3_DIR: p3_dir_r <= i_apb.pwdata[7:0];
                `PIO_ADDR_P4_DIR: p4_dir_r <= i_apb.pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // converter and mode controls
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ain_dis_r <= `PIO_RST_AIN_DIS;
            ain_sel_r <= '0;
            irq0_en_r <= 1'b0;
            dual_clk_r <= 1'b0;
        end else if (wr_en) begin
            if (we[10]) begin
                ain_dis_r <= i_apb.pwdata[`PIO_CONV_AIN_DIS_BIT];
                ain_sel_r <= i_apb.pwdata[`PIO_CONV_SEL_LSB +: `PIO_CONV_SEL_W];
            end
            if (we[11]) begin
                irq0_en_r <= i_apb.pwdata[`PIO_EXT_IRQ_ZERO_EN_BIT];
            end
            if (we[12]) begin
                dual_clk_r <= i_apb.pwdata[`PIO_MODE_DUAL_CLK_BIT];
            end
        end
    end

    // ext irq latch for port 2 bit 0: falling edge of the pad, even when self-driven
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            p20_prev_r <= 1'b1;
            irq0_flag_r <= 1'b0;
        end else begin
            p20_prev_r <= drv.p2[0] & i_pin.p2[0];
            if (p20_prev_r && !(drv.p2[0] & i_pin.p2[0])) begin
                irq0_flag_r <= 1'b1;
            end else if (we[11] && i_apb.pwdata[`PIO_EXT_IRQ_ZERO_FLAG_BIT]) begin
                irq0_flag_r <= 1'b0;
            end
        end
    end

    // drive values; open-drain ports follow latch AND secondary output
    always_comb begin
        drv.p0 = p0_latch_r & i_alt_out.p0;
        drv.p1 = p1_latch_r & i_alt_out.p1;
        drv.p2 = p2_latch_r & i_alt_out.p2;
        drv.p3 = p3_latch_r;
        drv.p4 = p4_latch_r;
        if (irq0_en_r) begin
            drv.p0[0] = 1'b1;
        end
        if (dual_clk_r) begin
            drv.p2[2:1] = 2'b11;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pin <= '0;
            o_pin_oe <= '0;
            o_ext_irq_zero_n <= 1'b1;
            o_ext_irq_p20_n <= 1'b1;
            o_sub_osc_sel <= 1'b0;
        end else begin
            o_pin <= drv;
            o_pin_oe.p0 <= ~drv.p0;
            o_pin_oe.p1 <= p1_dir_r;
            o_pin_oe.p2 <= ~drv.p2;
            o_pin_oe.p3 <= p3_dir_eff;
            o_pin_oe.p4 <= p4_dir_r;
            o_ext_irq_zero_n <= irq0_en_r ? i_pin.p0[0] : 1'b1;
            o_ext_irq_p20_n <= ~irq0_flag_r;
            o_sub_osc_sel <= dual_clk_r;
        end
    end

    always_comb begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        unique case (i_apb.paddr)
            `PIO_ADDR_P0_LATCH: rdata[7:0] = p0_latch_r;
            `PIO_ADDR_P0_PIN: rdata[7:0] = i_pin.p0;
            `PIO_ADDR_P1_LATCH: rdata[7:0] = {2'(`PIO_UNDEF_FILL), p1_rd};
            `PIO_ADDR_P1_DIR: rdata[7:0] = {2'(`PIO_UNDEF_FILL), p1_dir_r};
            `PIO_ADDR_P2_LATCH: rdata[7:0] = {5'(`PIO_UNDEF_FILL), p2_latch_r};
            `PIO_ADDR_P2_PIN: rdata[7:0] = {5'(`PIO_UNDEF_FILL), i_pin.p2};
            `PIO_ADDR_P3_LATCH: rdata[7:0] = p3_rd;
            `PIO_ADDR_P3_DIR: rdata[7:0] = p3_dir_r;
            `PIO_ADDR_P4_LATCH: rdata[7:0] = p4_rd;
            `PIO_ADDR_P4_DIR: rdata[7:0] = p4_dir_r;
            `PIO_ADDR_CONV: begin
                rdata[`PIO_CONV_AIN_DIS_BIT] = ain_dis_r;
                rdata[`PIO_CONV_SEL_LSB +: `PIO_CONV_SEL_W] = ain_sel_r;
            end
            `PIO_ADDR_EXT_IRQ: begin
                rdata[`PIO_EXT_IRQ_ZERO_EN_BIT] = irq0_en_r;
                rdata[`PIO_EXT_IRQ_ZERO_FLAG_BIT] = irq0_flag_r;
            end
            `PIO_ADDR_MODE: rdata[`PIO_MODE_DUAL_CLK_BIT] = dual_clk_r;
            default: hit = 1'b0;
        endcase
    end

    // zero-wait slave: pready in the access cycle; read data registered at setup
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_apb <= '0;
        end else begin
            o_apb.pready <= i_apb.psel && !i_apb.penable;
            o_apb.pslverr <= i_apb.psel && !i_apb.penable && !hit;
            // the pads are sampled here, so the word stands with pready in the access cycle
            if (i_apb.psel && !i_apb.penable) begin
                o_apb.prdata <= rdata;
            end
        end
    end
endmodule : pio_ports
`default_nettype wire
